//--- rtl/hac_top.sv
//
// Contract
// R1: each plate has a direct and an inverted channel moving opposite ways
// R2: phase held as sine and cosine times 256, used in angle math
// R3: host rewrites phase constants after every device reset
// R4: plate reference is one over twice the sum of channel reciprocals
// R5: tuning sets coarse, fine and compensation from base and target
// R6: first phase zeroes compensation, steps multipliers until reference meets base
// R7: then compensation rises until reference reaches target
// R8: host should use base 100 or 150, target 500 to 1000
// R9: track 0/180 degree crossings and extremes of both difference terms
// R10: ratio is kappa times top over bottom, kappa max bottom over max top
// R11: ratio constant updates only after both extremes seen between crossings
// R12: kappa starts at one, no compensation, until a qualifying rotation
// R13: amplitude compensation only in angle math, raw values stay raw
// R14: host rotates the magnet before trusting compensation after calibration
// R15: fixed-point arithmetic with consistent truncation and rounding
//
module hac_top (
  // clock, reset and enable
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // hall channel counts
  input wire logic [15:0] plate_one_direct_channel,
  input wire logic [15:0] plate_one_inverted_channel,
  input wire logic [15:0] plate_two_direct_channel,
  input wire logic [15:0] plate_two_inverted_channel,
  input wire logic sample_valid,
  // auto-tuning settings to the front end, index is plate
  output logic [1:0][3:0] auto_tuning_coarse_q,
  output logic [1:0][4:0] auto_tuning_fine_q,
  output logic [1:0][9:0] auto_tuning_comp_q,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [15:0] ch_w [4];
  logic [15:0] raw_q [4];
  logic [15:0] inv_q [4];
  logic v1_q;
  logic v2_q;
  logic [15:0] ref_q [2];
  logic signed [16:0] rt_q;
  logic signed [16:0] rb_q;
  logic [7:0] sin_q;
  logic [7:0] cos_q;
  logic [9:0] base_q [2];
  logic [9:0] target_q [2];
  logic track_en_q;
  logic start_q;
  hac_pkg::hac_tune_e tune_st_q [2];
  hac_pkg::hac_tune_e tune_st_d [2];
  logic [1:0][3:0] coarse_d;
  logic [1:0][4:0] fine_d;
  logic [1:0][9:0] comp_d;
  logic [15:0] kappa_q;
  logic kvalid_q;
  logic [15:0] pk_t_q;
  logic [15:0] pk_b_q;
  logic seen_t_q;
  logic seen_b_q;
  logic portion_ok_q;
  logic have_prev_q;
  logic rt_neg_q;
  logic [15:0] ratio_q;
  logic [15:0] quad_s_q;
  logic [15:0] quad_c_q;
  logic [7:0] awaddr_q;
  logic aw_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_held_q;

  // ****************************************************************
  // arithmetic helpers
  // ****************************************************************

  // scaled reciprocal, saturating, zero count reads as largest
  function automatic logic [15:0] recip(input logic [15:0] x);
    logic [24:0] q;
    q = 25'h0000000;
    if (x == 16'h0000)
      recip = 16'hFFFF;
    else
    begin
      q = hac_pkg::RECIP_NUM / {9'h000, x};
      recip = (q > 25'h000FFFF) ? 16'hFFFF : q[15:0];
    end
  endfunction

  // reference counts from the two reciprocals of one plate
  function automatic logic [15:0] ref_of(input logic [15:0] a, input logic [15:0] b);
    logic [17:0] den;
    logic [24:0] q;
    den = {({1'b0, a} + {1'b0, b}), 1'b0};
    q = 25'h0000000;
    if (den == 18'h00000)
      ref_of = 16'hFFFF;
    else
    begin
      q = hac_pkg::RECIP_NUM / {7'h00, den};
      ref_of = (q > 25'h000FFFF) ? 16'hFFFF : q[15:0];
    end
  endfunction

  // channel order: plate one direct, inverted, plate two direct, inverted
  assign ch_w[0] = plate_one_direct_channel;
  assign ch_w[1] = plate_one_inverted_channel;
  assign ch_w[2] = plate_two_direct_channel;
  assign ch_w[3] = plate_two_inverted_channel;

  // ****************************************************************
  // stage 1: raw capture and reciprocals
  // ****************************************************************

  // R13: raw kept untouched
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      v1_q <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        raw_q[i] <= 16'h0000;
        inv_q[i] <= 16'h0000;
      end
    end
    else if (ce)
    begin
      v1_q <= sample_valid;
      if (sample_valid)
        for (int i = 0; i < 4; i++)
        begin
          raw_q[i] <= ch_w[i];
          // R15: truncating reciprocal
          inv_q[i] <= recip(ch_w[i]);
        end
    end
  end

  // ****************************************************************
  // stage 2: plate references and difference terms
  // ****************************************************************

  // R4: reference per plate
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      v2_q <= 1'b0;
      ref_q[0] <= 16'h0000;
      ref_q[1] <= 16'h0000;
      rt_q <= 17'sh00000;
      rb_q <= 17'sh00000;
    end
    else if (ce)
    begin
      v2_q <= v1_q;
      if (v1_q)
      begin
        ref_q[0] <= ref_of(inv_q[0], inv_q[1]);
        ref_q[1] <= ref_of(inv_q[2], inv_q[3]);
        // R10: top and bottom differences
        rt_q <= $signed({1'b0, inv_q[2]}) - $signed({1'b0, inv_q[0]});
        // R1: inverted pair forms the bottom term
        rb_q <= $signed({1'b0, inv_q[3]}) - $signed({1'b0, inv_q[1]});
      end
    end
  end

  // ****************************************************************
  // stage 3: compensated ratio and phase-corrected quadrature
  // ****************************************************************
  logic signed [33:0] krt_w;
  logic signed [33:0] ratio_w;
  logic signed [25:0] y_w;
  logic signed [34:0] cos_term_w;
  logic signed [35:0] diff_w;
  logic signed [35:0] quadc_w;

  // R10: kappa times top over bottom, kappa in 8.8
  assign krt_w = $signed({1'b0, kappa_q}) * rt_q;
  assign ratio_w = krt_w / $signed({{17{rb_q[16]}}, rb_q});
  // R2: phase applied through its sine and cosine
  assign y_w = krt_w[33:8];
  assign cos_term_w = y_w * $signed({1'b0, cos_q});
  assign diff_w = $signed({{11{rb_q[16]}}, rb_q, 8'h00})
                  - $signed({cos_term_w[34], cos_term_w});
  assign quadc_w = diff_w / $signed({28'h0000000, sin_q});

  // R13: compensation lives only here
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ratio_q <= 16'h0000;
      quad_s_q <= 16'h0000;
      quad_c_q <= 16'h0000;
    end
    else if (ce && v2_q)
    begin
      if (rb_q != 17'sh00000)
        ratio_q <= ratio_w[15:0];
      quad_s_q <= y_w[15:0];
      if (sin_q != 8'h00)
        quad_c_q <= quadc_w[15:0];
    end
  end

  // ****************************************************************
  // rotation tracking and compensation constant
  // ****************************************************************
  logic signed [16:0] rt_neg_w;
  logic signed [16:0] rb_neg_w;
  logic [15:0] at_w;
  logic [15:0] ab_w;
  logic cross_w;
  logic qualify_w;
  logic [23:0] knum_w;
  logic [23:0] kquo_w;

  // magnitudes cover maxima in one half and minima in the other
  assign rt_neg_w = -rt_q;
  assign rb_neg_w = -rb_q;
  assign at_w = rt_q[16] ? rt_neg_w[15:0] : rt_q[15:0];
  assign ab_w = rb_q[16] ? rb_neg_w[15:0] : rb_q[15:0];
  // R9: sign change of top term marks 0 or 180 degrees
  assign cross_w = have_prev_q & (rt_q[16] != rt_neg_q);
  // R11: whole portion with both extremes passed
  assign qualify_w = cross_w & portion_ok_q & seen_t_q & seen_b_q & (pk_t_q != 16'h0000);
  // R15: rounded kappa so repeated rotations settle
  assign knum_w = {pk_b_q, 8'h00} + {9'h000, pk_t_q[15:1]};
  assign kquo_w = (pk_t_q == 16'h0000) ? 24'hFFFFFF : knum_w / {8'h00, pk_t_q};

  // per-portion peak tracking
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // R12: start with no compensation
      kappa_q <= hac_pkg::KAPPA_ONE;
      kvalid_q <= 1'b0;
      pk_t_q <= 16'h0000;
      pk_b_q <= 16'h0000;
      seen_t_q <= 1'b0;
      seen_b_q <= 1'b0;
      portion_ok_q <= 1'b0;
      have_prev_q <= 1'b0;
      rt_neg_q <= 1'b0;
    end
    else if (ce && v2_q && track_en_q)
    begin
      have_prev_q <= 1'b1;
      rt_neg_q <= rt_q[16];
      if (cross_w)
      begin
        // R11: otherwise prior kappa kept
        if (qualify_w)
        begin
          kappa_q <= (kquo_w > 24'h00FFFF) ? 16'hFFFF : kquo_w[15:0];
          kvalid_q <= 1'b1;
        end
        portion_ok_q <= 1'b1;
        pk_t_q <= at_w;
        pk_b_q <= ab_w;
        seen_t_q <= 1'b0;
        seen_b_q <= 1'b0;
      end
      else
      begin
        // R9: extreme passed once magnitude falls back
        if (at_w > pk_t_q)
          pk_t_q <= at_w;
        else if ((pk_t_q - at_w) > hac_pkg::PEAK_HYST)
          seen_t_q <= 1'b1;
        if (ab_w > pk_b_q)
          pk_b_q <= ab_w;
        else if ((pk_b_q - ab_w) > hac_pkg::PEAK_HYST)
          seen_b_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // auto-tuning per plate
  // ****************************************************************

  // R5: three settings from base and target
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      tune_st_d[p] = tune_st_q[p];
      coarse_d[p] = auto_tuning_coarse_q[p];
      fine_d[p] = auto_tuning_fine_q[p];
      comp_d[p] = auto_tuning_comp_q[p];
      case (tune_st_q[p])
        hac_pkg::TUNE_IDLE, hac_pkg::TUNE_DONE:
          if (start_q)
          begin
            tune_st_d[p] = hac_pkg::TUNE_COARSE;
            coarse_d[p] = 4'h0;
            fine_d[p] = 5'h00;
            comp_d[p] = 10'h000;
          end
        hac_pkg::TUNE_COARSE:
        begin
          // R6: compensation held at zero
          comp_d[p] = 10'h000;
          if (v2_q)
          begin
            if (ref_q[p] < {6'h00, base_q[p]})
            begin
              if (auto_tuning_coarse_q[p] == hac_pkg::COARSE_MAX)
                tune_st_d[p] = hac_pkg::TUNE_FINE;
              else
                coarse_d[p] = auto_tuning_coarse_q[p] + 4'h1;
            end
            else
            begin
              // back off one coarse step, fine closes the gap
              if (auto_tuning_coarse_q[p] != 4'h0)
                coarse_d[p] = auto_tuning_coarse_q[p] - 4'h1;
              tune_st_d[p] = hac_pkg::TUNE_FINE;
            end
          end
        end
        hac_pkg::TUNE_FINE:
          // R6: fine steps up to base
          if (v2_q)
          begin
            if (ref_q[p] < {6'h00, base_q[p]} && auto_tuning_fine_q[p] != hac_pkg::FINE_MAX)
              fine_d[p] = auto_tuning_fine_q[p] + 5'h01;
            else
              tune_st_d[p] = hac_pkg::TUNE_COMP;
          end
        hac_pkg::TUNE_COMP:
          // R7: compensation rises to target
          if (v2_q)
          begin
            if (ref_q[p] < {6'h00, target_q[p]} && auto_tuning_comp_q[p] != hac_pkg::COMP_MAX)
              comp_d[p] = auto_tuning_comp_q[p] + 10'h001;
            else
              tune_st_d[p] = hac_pkg::TUNE_DONE;
          end
        default:
          tune_st_d[p] = hac_pkg::TUNE_IDLE;
      endcase
    end
  end

  // tuning registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tune_st_q[0] <= hac_pkg::TUNE_IDLE;
      tune_st_q[1] <= hac_pkg::TUNE_IDLE;
      auto_tuning_coarse_q <= '0;
      auto_tuning_fine_q <= '0;
      auto_tuning_comp_q <= '0;
    end
    else if (ce)
    begin
      tune_st_q <= tune_st_d;
      auto_tuning_coarse_q <= coarse_d;
      auto_tuning_fine_q <= fine_d;
      auto_tuning_comp_q <= comp_d;
    end
  end

  // ****************************************************************
  // axi4-lite slave: write path
  // ****************************************************************
  logic wr_fire_w;
  logic [31:0] wmask_w;
  logic [7:0] wword_w;
  logic [31:0] phase_old_w;
  logic [31:0] phase_new_w;
  logic [31:0] tune_old_w [2];
  logic [31:0] tune_new_w [2];
  logic wr_known_w;

  // decode of a held write
  assign wr_fire_w = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign wmask_w = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wword_w = {awaddr_q[7:2], 2'b00};
  assign phase_old_w = {16'h0000, cos_q, sin_q};
  assign phase_new_w = (phase_old_w & ~wmask_w) | (wdata_q & wmask_w);
  assign tune_old_w[0] = {6'h00, target_q[0], 6'h00, base_q[0]};
  assign tune_old_w[1] = {6'h00, target_q[1], 6'h00, base_q[1]};
  assign tune_new_w[0] = (tune_old_w[0] & ~wmask_w) | (wdata_q & wmask_w);
  assign tune_new_w[1] = (tune_old_w[1] & ~wmask_w) | (wdata_q & wmask_w);
  assign wr_known_w = (wword_w <= hac_pkg::OFF_MULT_P2);

  // address and data taken in either order, answer after both
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= hac_pkg::RESP_OKAY;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_q <= s_axi_awaddr;
        aw_held_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_held_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire_w)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known_w ? hac_pkg::RESP_OKAY : hac_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // writable settings
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      track_en_q <= hac_pkg::TRACK_RST;
      start_q <= 1'b0;
      // R3: constants lost at reset, host rewrites them
      sin_q <= hac_pkg::PHASE_RST;
      cos_q <= hac_pkg::PHASE_RST;
      for (int p = 0; p < 2; p++)
      begin
        base_q[p] <= hac_pkg::TUNE_BASE_RST;
        target_q[p] <= hac_pkg::TUNE_TARGET_RST;
      end
    end
    else if (ce)
    begin
      start_q <= wr_fire_w && wword_w == hac_pkg::OFF_CTRL && wstrb_q[0]
                 && wdata_q[hac_pkg::CTRL_START_BIT];
      if (wr_fire_w && wword_w == hac_pkg::OFF_CTRL && wstrb_q[0])
        track_en_q <= wdata_q[hac_pkg::CTRL_TRACK_BIT];
      // R2: sine and cosine of the phase, times 256
      if (wr_fire_w && wword_w == hac_pkg::OFF_PHASE)
      begin
        sin_q <= phase_new_w[hac_pkg::PHASE_SIN_LSB +: hac_pkg::PH_W];
        cos_q <= phase_new_w[hac_pkg::PHASE_COS_LSB +: hac_pkg::PH_W];
      end
      for (int p = 0; p < 2; p++)
        if (wr_fire_w && wword_w == (p == 0 ? hac_pkg::OFF_TUNE_P1 : hac_pkg::OFF_TUNE_P2))
        begin
          base_q[p] <= tune_new_w[p][hac_pkg::TUNE_BASE_LSB +: hac_pkg::TUNE_W];
          target_q[p] <= tune_new_w[p][hac_pkg::TUNE_TARGET_LSB +: hac_pkg::TUNE_W];
        end
    end
  end

  // ****************************************************************
  // axi4-lite slave: read path
  // ****************************************************************
  logic [7:0] rword_w;
  logic [31:0] rmux_w;
  logic rknown_w;
  logic [31:0] status_w;
  logic [31:0] mult_w [2];

  assign rword_w = {s_axi_araddr[7:2], 2'b00};

  // status and tuning result words
  always_comb
  begin
    status_w = 32'h00000000;
    for (int p = 0; p < 2; p++)
    begin
      status_w[hac_pkg::STAT_DONE_LSB + p] = (tune_st_q[p] == hac_pkg::TUNE_DONE);
      status_w[hac_pkg::STAT_BUSY_LSB + p] = (tune_st_q[p] != hac_pkg::TUNE_DONE)
                                             && (tune_st_q[p] != hac_pkg::TUNE_IDLE);
      mult_w[p] = 32'h00000000;
      mult_w[p][hac_pkg::MULT_COMP_LSB +: hac_pkg::COMP_W] = auto_tuning_comp_q[p];
      mult_w[p][hac_pkg::MULT_FINE_LSB +: hac_pkg::FINE_W] = auto_tuning_fine_q[p];
      mult_w[p][hac_pkg::MULT_COARSE_LSB +: hac_pkg::COARSE_W] = auto_tuning_coarse_q[p];
    end
    status_w[hac_pkg::STAT_KVALID_BIT] = kvalid_q;
  end

  // read selection
  always_comb
  begin
    rknown_w = 1'b1;
    case (rword_w)
      hac_pkg::OFF_CTRL: rmux_w = {30'h00000000, track_en_q, 1'b0};
      hac_pkg::OFF_STATUS: rmux_w = status_w;
      hac_pkg::OFF_PHASE: rmux_w = phase_old_w;
      hac_pkg::OFF_TUNE_P1: rmux_w = tune_old_w[0];
      hac_pkg::OFF_TUNE_P2: rmux_w = tune_old_w[1];
      hac_pkg::OFF_RAW_P1: rmux_w = {raw_q[1], raw_q[0]};
      hac_pkg::OFF_RAW_P2: rmux_w = {raw_q[3], raw_q[2]};
      hac_pkg::OFF_REF: rmux_w = {ref_q[1], ref_q[0]};
      hac_pkg::OFF_KAPPA: rmux_w = {16'h0000, kappa_q};
      hac_pkg::OFF_RATIO: rmux_w = {16'h0000, ratio_q};
      hac_pkg::OFF_QUAD: rmux_w = {quad_c_q, quad_s_q};
      hac_pkg::OFF_MULT_P1: rmux_w = mult_w[0];
      hac_pkg::OFF_MULT_P2: rmux_w = mult_w[1];
      default:
      begin
        rmux_w = 32'h00000000;
        rknown_w = 1'b0;
      end
    endcase
  end

  // one read at a time, data registered at the address edge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= hac_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rmux_w;
        s_axi_rresp <= rknown_w ? hac_pkg::RESP_OKAY : hac_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

//--- rtl/hac_pkg.sv
package hac_pkg;

  // ****************************************************************
  // register map, byte addresses of one aligned 32-bit word each
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_PHASE = 8'h08;
  localparam logic [7:0] OFF_TUNE_P1 = 8'h0C;
  localparam logic [7:0] OFF_TUNE_P2 = 8'h10;
  localparam logic [7:0] OFF_RAW_P1 = 8'h14;
  localparam logic [7:0] OFF_RAW_P2 = 8'h18;
  localparam logic [7:0] OFF_REF = 8'h1C;
  localparam logic [7:0] OFF_KAPPA = 8'h20;
  localparam logic [7:0] OFF_RATIO = 8'h24;
  localparam logic [7:0] OFF_QUAD = 8'h28;
  localparam logic [7:0] OFF_MULT_P1 = 8'h2C;
  localparam logic [7:0] OFF_MULT_P2 = 8'h30;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_TRACK_BIT = 1;
  localparam int STAT_DONE_LSB = 0;
  localparam int STAT_KVALID_BIT = 2;
  localparam int STAT_BUSY_LSB = 3;
  localparam int PHASE_SIN_LSB = 0;
  localparam int PHASE_COS_LSB = 8;
  localparam int TUNE_BASE_LSB = 0;
  localparam int TUNE_TARGET_LSB = 16;
  localparam int MULT_COMP_LSB = 0;
  localparam int MULT_FINE_LSB = 16;
  localparam int MULT_COARSE_LSB = 24;
  localparam int HALF_LSB = 16;

  // ****************************************************************
  // widths, limits and reset values
  // ****************************************************************
  localparam int CH_W = 16;
  localparam int COARSE_W = 4;
  localparam int FINE_W = 5;
  localparam int COMP_W = 10;
  localparam int TUNE_W = 10;
  localparam int PH_W = 8;
  localparam int KAPPA_W = 16;
  localparam logic [3:0] COARSE_MAX = 4'hF;
  localparam logic [4:0] FINE_MAX = 5'h1F;
  localparam logic [9:0] COMP_MAX = 10'h3FF;
  localparam logic TRACK_RST = 1'b1;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam logic [9:0] TUNE_BASE_RST = 10'h064;
  localparam logic [9:0] TUNE_TARGET_RST = 10'h2EE;
  localparam logic [15:0] KAPPA_ONE = 16'h0100;
  localparam logic [24:0] RECIP_NUM = 25'h1000000;
  localparam logic [15:0] PEAK_HYST = 16'h0010;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // auto-tuning sequence per plate
  typedef enum logic [2:0] {
    TUNE_IDLE = 3'b000,
    TUNE_COARSE = 3'b001,
    TUNE_FINE = 3'b010,
    TUNE_COMP = 3'b011,
    TUNE_DONE = 3'b100
  } hac_tune_e;

endpackage

//--- sim/hac_checker.sv
module hac_checker (
  // watched ports
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0][3:0] auto_tuning_coarse_q,
  input wire logic [1:0][9:0] auto_tuning_comp_q
);
  // ****************************************
  // bus and tuning checks
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence aw_take; s_axi_awvalid && s_axi_awready && ce; endsequence
  sequence ar_take; s_axi_arvalid && s_axi_arready && ce; endsequence
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  chk_aw_refused: assert property (aw_take |=> !s_axi_awready)
    else $error("second write taken");
  chk_ar_answer: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_r_release: assert property (s_axi_rvalid && s_axi_rready && ce |=> !s_axi_rvalid)
    else $error("read answer kept");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready && ce |=> !s_axi_bvalid)
    else $error("write answer kept");
  chk_coarse_nocomp: assert property ($changed(auto_tuning_coarse_q[0]) |->
    auto_tuning_comp_q[0] == '0)
    else $error("compensation not zero");
  chk_comp_step: assert property ($changed(auto_tuning_comp_q[0]) |->
    auto_tuning_comp_q[0] == $past(auto_tuning_comp_q[0]) + 10'h001 || auto_tuning_comp_q[0] == '0)
    else $error("compensation jumped");
endmodule

bind hac_top hac_checker u_chk (.*);

//--- sim/hac_host.sv
module hac_host (
  // clock
  input wire logic clock,
  // bus master side
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // host bus tasks
  // ****************************************
  initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
  initial {s_axi_araddr, s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 14'h000F;
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    forever
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    forever
    begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic init(input logic [15:0] ph);
    logic [1:0] r;
    wr(hac_pkg::OFF_PHASE, {16'h0000, ph}, r);
    wr(hac_pkg::OFF_TUNE_P1, 32'h01F4_0096, r);
    wr(hac_pkg::OFF_TUNE_P2, 32'h01F4_0096, r);
  endtask
endmodule

//--- sim/hall_angle_compensation_tb.sv
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t got %h exp %h", $time, a, b); end end
module hall_angle_compensation_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic sample_valid = 1'b0;
  logic [15:0] plate_one_direct_channel = 16'h0200, plate_one_inverted_channel = 16'h0200;
  logic [15:0] plate_two_direct_channel = 16'h0400, plate_two_inverted_channel = 16'h0C00;
  logic [31:0] rot [4] = '{32'h0800_0800, 32'h0200_0400, 32'h0400_0800, 32'h0800_0200};
  logic [1:0][3:0] auto_tuning_coarse_q;
  logic [1:0][4:0] auto_tuning_fine_q;
  logic [1:0][9:0] auto_tuning_comp_q;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_fail = 0;
  int checks_done = 0;
  // ****************************************
  // design, host and run control
  // ****************************************
  hac_top DUT (.*);
  hac_host H (.*);
  always #4 clock = ~clock;
  initial
  begin
    #50000;
    n_fail++;
    wrap_up();
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // reset, setup, raw and reference, tuning, then a rotation and the compensation results
  initial
  begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    H.rd(hac_pkg::OFF_KAPPA, d, r);
    `CHK(d, {16'h0000, hac_pkg::KAPPA_ONE})
    H.init(16'hDA83);
    H.rd(hac_pkg::OFF_PHASE, d, r);
    `CHK(d[15:0], 16'hDA83)
    H.rd(8'h34, d, r);
    `CHK({r, d}, {hac_pkg::RESP_SLVERR, 32'h0000_0000})
    sample_valid <= 1'b1;
    H.wr(hac_pkg::OFF_RAW_P2, 32'hFFFF_FFFF, r);
    `CHK(r, hac_pkg::RESP_OKAY)
    H.rd(hac_pkg::OFF_RAW_P2, d, r);
    `CHK(d, 32'h0C00_0400)
    H.rd(hac_pkg::OFF_REF, d, r);
    `CHK(d, 32'h0180_0080)
    H.wr(hac_pkg::OFF_CTRL, 32'h0000_0003, r);
    d = '0;
    for (int i = 0; i < 500 && d[1:0] !== 2'b11; i++) H.rd(hac_pkg::OFF_STATUS, d, r);
    `CHK(d[2:0], 3'b011)
    H.rd(hac_pkg::OFF_MULT_P1, d, r);
    `CHK(d, 32'h0F1F_03FF)
    `CHK({auto_tuning_coarse_q, auto_tuning_comp_q}, 28'h0F_FFFFF)
    H.rd(hac_pkg::OFF_KAPPA, d, r);
    `CHK(d[15:0], hac_pkg::KAPPA_ONE)
    {plate_one_direct_channel, plate_one_inverted_channel} <= 32'h0400_0800;
    for (int s = 0; s < 4; s++)
    begin
      {plate_two_direct_channel, plate_two_inverted_channel} <= rot[s];
      repeat (4) @(posedge clock);
    end
    H.rd(hac_pkg::OFF_KAPPA, d, r);
    `CHK(d, 32'h0000_0080)
    H.rd(hac_pkg::OFF_RATIO, d, r);
    `CHK(d, 32'h0000_FFD6)
    H.rd(hac_pkg::OFF_QUAD, d, r);
    `CHK(d, 32'hD63A_F000)
    H.rd(hac_pkg::OFF_STATUS, d, r);
    `CHK(d[2], 1'b1)
    wrap_up();
  end
endmodule
